//--- ipc_cache.sv
// Purpose: instruction prefetch cache with look-ahead/look-back counters
// Assumes: memory load pipeline answers in order; decode supplies length
// Notes: single clock; outputs registered
//
// Contract
// - 32 words, 128 bytes, circular unstructured store
// - look-ahead highest, look-back lowest word address
// - each prefetch adds four to look-ahead
// - fetched word goes to look-ahead slot
// - look-back advances only when slot overwritten
// - slot indices wrap modulo 32
// - stop at eight words past pointer
// - pause before memory or branching instructions
// - pause during memory or I/O execution
// - at most two loads outstanding (a flush raises its target request whatever the count)
// - read by pointer bits 6..1
// - wait until needed halfwords are present
// - short branch target range check
// - cached target keeps counters, no flush
// - loop-hold delayed forward miss keeps counters
// - other taken branch flushes, loads counters
// - long branch always flushes
// - loop-hold is status bit four, logic-writable
// - loop-hold cleared by frame and by branches other than delayed short and return
`timescale 1ns/1ps
module ipc_cache
    import ipc_pkg::*;
#(
    parameter logic [31:0] START_ADDR = 32'h0000_0000
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic ce, // clock enable
    // memory load pipeline side
    output logic fetch_req, // start word fetch
    output logic [31:0] fetch_addr, // word address
    input wire logic fetch_accept, // pipeline took request
    input wire logic fetch_valid, // fetched word returns
    input wire logic [31:0] fetch_data, // fetched word
    // decode side
    input wire logic [31:0] instruction_pointer, // current decode address
    input wire logic [1:0] dec_len, // halfwords needed, 1..3
    output logic dec_ready, // instruction complete in cache
    output logic [47:0] dec_data, // up to three halfwords
    // execution control
    input wire logic pause_next, // next cycle executes mem or branch op
    input wire logic mem_exec, // memory or I/O executing
    input wire logic branch_taken, // branch taken this cycle
    input wire ipc_branch_type branch_kind, // kind of branch
    input wire logic in_delay_slot, // branch sits in delay slot
    input wire logic [31:0] branch_target, // target address
    input wire logic frame_exec, // frame instruction executes
    input wire logic status_wr, // logical op writes status
    input wire logic status_wr_bit, // new loop-hold value
    input wire logic return_restore, // return restores status
    input wire logic saved_loop_hold, // saved status bit four
    output logic loop_hold, // loop-hold flag
    output logic target_cached // last checked branch was in cache
);
    logic [31:0] ahead_q; // look-ahead
    logic [31:0] back_q; // look-back
    logic [31:0] filled_q; // highest word actually stored
    logic empty_q;
    logic [1:0] pend_q; // loads outstanding
    logic lh_q;
    logic fetch_req_q;
    logic [31:0] fetch_addr_q;
    logic dec_ready_q;
    logic [47:0] dec_data_q;
    logic cached_q;
    logic [31:0] ip_word;
    logic [31:0] span;
    logic short_br;
    logic in_range;
    logic hold_wait;
    logic flush;
    logic issue;
    logic pipe_room;
    logic f_valid;
    logic f_ready;
    logic [31:0] f_data;
    logic [31:0] wr_addr;
    logic [47:0] rd_data;
    logic [31:0] last_need;
    logic need_in;
    logic took; // request taken at this edge
    logic [31:0] ahead_eff; // look-ahead counting a request taken now
    logic [1:0] pend_d; // loads outstanding after this edge
    logic [1:0] drop_q; // stale loads still to be discarded
    logic fill_in; // returned word belongs to the current stream

    //--------------------------------------------------------------
    // parameter checks
    //--------------------------------------------------------------
    // counters and slots assume a word-aligned start
    initial begin
        if (START_ADDR[1:0] != 2'b00) $error("start address must be word aligned");
    end

    //--------------------------------------------------------------
    // branch classification
    //--------------------------------------------------------------
    // target test for one-halfword branches outside delay slots
    assign short_br = (branch_kind == IPC_BR_SHORT || branch_kind == IPC_BR_SHORT_DELAYED)
                      && !in_delay_slot;
    assign in_range = (branch_target < instruction_pointer) ?
                      (branch_target >= back_q) :
                      (branch_target <= ahead_q + IPC_FWD_SLACK);
    assign hold_wait = branch_taken && short_br && !in_range && lh_q
                       && branch_kind == IPC_BR_SHORT_DELAYED
                       && branch_target >= instruction_pointer;
    // flush unless target judged cached or loop-hold keeps it
    assign flush = branch_taken && !(short_br && in_range) && !hold_wait;

    //--------------------------------------------------------------
    // prefetch control
    //--------------------------------------------------------------
    // a request taken at this edge already counts as started
    assign took = fetch_req_q && fetch_accept;
    assign ahead_eff = took ? fetch_addr_q : ahead_q;
    assign ip_word = {instruction_pointer[31:2], 2'b00};
    // negative span: pointer ran past look-ahead, keep fetching
    assign span = ahead_eff - ip_word;
    assign pend_d = pend_q + 2'(took) - 2'(fetch_valid);
    // count the load taken now so issue never raises a third; a flush request ignores the count
    assign pipe_room = pend_d < 2'(IPC_PIPE_DEPTH);
    // issue while under limit and not paused
    assign issue = !flush && !empty_q && pipe_room && f_ready
                   && (span[31] || span < IPC_LIMIT_BYTES)
                   && !pause_next && !mem_exec;

    // request outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            fetch_req_q <= 1'b0;
            fetch_addr_q <= START_ADDR;
        end else if (ce) begin
            if (flush) begin
                fetch_req_q <= 1'b1;
                fetch_addr_q <= {branch_target[31:2], 2'b00};
            end else if (fetch_req_q && !fetch_accept) begin
                fetch_req_q <= 1'b1; // raised request stands until taken
            end else if (issue) begin
                fetch_req_q <= 1'b1;
                fetch_addr_q <= ahead_eff + IPC_WORD_STEP;
            end else begin
                // an empty cache asks once for the start word
                fetch_req_q <= empty_q && !took;
            end
        end
    end
    assign fetch_req = fetch_req_q;
    assign fetch_addr = fetch_addr_q;

    // look-ahead counter, marks last word whose cycle started
    always_ff @(posedge clk) begin
        if (rst) begin
            ahead_q <= START_ADDR;
            empty_q <= 1'b1;
        end else if (ce) begin
            if (flush) begin
                ahead_q <= {branch_target[31:2], 2'b00};
                empty_q <= 1'b0;
            end else if (fetch_req_q && fetch_accept && !empty_q
                         && fetch_addr_q != ahead_q) begin
                ahead_q <= ahead_q + IPC_WORD_STEP;
            end else if (empty_q && fetch_req_q && fetch_accept) begin
                ahead_q <= {START_ADDR[31:2], 2'b00};
                empty_q <= 1'b0;
            end
        end
    end

    // outstanding load count
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= '0;
        end else if (ce) begin
            pend_q <= pend_d;
        end
    end

    //--------------------------------------------------------------
    // stale loads
    //--------------------------------------------------------------
    // loads started before a flush still return and are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            drop_q <= '0;
        end else if (ce) begin
            if (flush) begin
                drop_q <= pend_d;
            end else if (fetch_valid && drop_q != 2'h0) begin
                drop_q <= drop_q - 2'h1;
            end
        end
    end
    assign fill_in = fetch_valid && drop_q == 2'h0;

    //--------------------------------------------------------------
    // fill path
    //--------------------------------------------------------------
    // fifo decouples returned words from the store
    ipc_fifo #(.WIDTH(IPC_WORD_W), .DEPTH(IPC_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .flush(flush),
        .in_valid(fill_in), // stale words never enter
        .in_ready(f_ready),
        .in_data(fetch_data),
        .out_valid(f_valid),
        .out_ready(1'b1),
        .out_data(f_data)
    );
    assign wr_addr = filled_q + IPC_WORD_STEP;

    ipc_store #(.WORDS(IPC_WORDS)) u_store (
        .clk(clk),
        .ce(ce),
        .wr_en(f_valid && !flush),
        .wr_slot(wr_addr[IPC_SLOT_MSB:IPC_SLOT_LSB]),
        .wr_data(f_data),
        .rd_hw(instruction_pointer[IPC_SLOT_MSB:IPC_HW_LSB]),
        .rd_data(rd_data)
    );

    // stored-word tracker and look-back counter
    always_ff @(posedge clk) begin
        if (rst) begin
            filled_q <= START_ADDR - IPC_WORD_STEP;
            back_q <= START_ADDR;
        end else if (ce) begin
            if (flush) begin
                filled_q <= {branch_target[31:2], 2'b00} - IPC_WORD_STEP;
                back_q <= {branch_target[31:2], 2'b00};
            end else if (f_valid) begin
                filled_q <= wr_addr;
                if (wr_addr[IPC_SLOT_MSB:IPC_SLOT_LSB] == back_q[IPC_SLOT_MSB:IPC_SLOT_LSB]
                    && wr_addr != back_q) begin
                    back_q <= back_q + IPC_WORD_STEP;
                end
            end
        end
    end

    //--------------------------------------------------------------
    // decode read
    //--------------------------------------------------------------
    assign last_need = instruction_pointer + {29'h0, dec_len, 1'b0} - 32'h0000_0002;
    assign need_in = (instruction_pointer >= back_q)
                     && ({last_need[31:2], 2'b00} <= filled_q)
                     && !(filled_q < back_q);
    // decode handshake registered
    always_ff @(posedge clk) begin
        if (rst || (ce && flush)) begin
            dec_ready_q <= 1'b0;
            dec_data_q <= '0;
        end else if (ce) begin
            dec_ready_q <= need_in && dec_len != 2'h0;
            dec_data_q <= rd_data;
        end
    end
    assign dec_ready = dec_ready_q;
    assign dec_data = dec_data_q;

    // branch judgement report
    always_ff @(posedge clk) begin
        if (rst) begin
            cached_q <= 1'b0;
        end else if (ce && branch_taken) begin
            cached_q <= short_br && in_range;
        end
    end
    assign target_cached = cached_q;

    //--------------------------------------------------------------
    // loop-hold flag
    //--------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            lh_q <= 1'b0;
        end else if (ce) begin
            if (return_restore) begin
                lh_q <= saved_loop_hold;
            end else if (frame_exec || (branch_taken && branch_kind != IPC_BR_SHORT_DELAYED
                         && branch_kind != IPC_BR_RETURN)) begin
                lh_q <= 1'b0;
            end else if (status_wr) begin
                lh_q <= status_wr_bit;
            end
        end
    end
    assign loop_hold = lh_q;

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    sequence s_flush;
        ce && flush;
    endsequence
    sequence s_clean;
        !f_valid && !branch_taken;
    endsequence
    sequence s_taken;
        ce && took && !flush;
    endsequence
    sequence s_stale;
        ce && fetch_valid && drop_q != 2'h0;
    endsequence
    AST_PEND_MAX: assert property (@(posedge clk) disable iff (rst) pend_q <= 2'd2)
        else $error("more than two loads outstanding");
    AST_FLUSH_CTRS: assert property (@(posedge clk) disable iff (rst)
        s_flush |=> (ahead_q == back_q) && fetch_req)
        else $error("flush did not load both counters");
    AST_KEEP: assert property (@(posedge clk) disable iff (rst)
        (ce && branch_taken && short_br && in_range && !f_valid) |=> $stable(back_q))
        else $error("cached branch moved look-back");
    AST_LONG: assert property (@(posedge clk) disable iff (rst)
        (ce && branch_taken && branch_kind == IPC_BR_LONG) |-> flush)
        else $error("long branch did not flush");
    AST_PAUSE: assert property (@(posedge clk) disable iff (rst)
        (ce && (pause_next || mem_exec) && !flush && !empty_q && !fetch_req) |=> !fetch_req)
        else $error("prefetch issued while paused");
    AST_FRAME: assert property (@(posedge clk) disable iff (rst)
        (ce && frame_exec && !return_restore) |=> !loop_hold)
        else $error("frame left loop-hold set");
    AST_BACK_STEP: assert property (@(posedge clk) disable iff (rst)
        ((ce && !flush) and s_clean) |=> $stable(back_q))
        else $error("look-back moved without a write");
    AST_LIMIT: assert property (@(posedge clk) disable iff (rst)
        (ce && !flush && !empty_q && !fetch_req && !span[31] && span >= IPC_LIMIT_BYTES)
        |=> !fetch_req)
        else $error("prefetch beyond eight words");
    AST_ASCEND: assert property (@(posedge clk) disable iff (rst)
        s_taken |=> !fetch_req || fetch_addr == $past(fetch_addr) + IPC_WORD_STEP)
        else $error("fetch address did not step by one word");
    AST_DROP: assert property (@(posedge clk) disable iff (rst)
        s_stale |=> !f_valid)
        else $error("stale word reached the store");
endmodule // ipc_cache

//--- ipc_fifo.sv
// Purpose: small valid/ready word FIFO in the fetched-data path
// Assumes: single clock, synchronous reset
// Notes: honest full and empty, stalls the writer when full
`timescale 1ns/1ps
module ipc_fifo
    import ipc_pkg::*;
#(
    parameter int WIDTH = IPC_WORD_W,
    parameter int DEPTH = IPC_FIFO_DEPTH
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic ce, // clock enable
    input wire logic flush, // drop contents
    input wire logic in_valid, // writer has data
    output logic in_ready, // room available
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // data available
    input wire logic out_ready, // reader takes
    output logic [WIDTH-1:0] out_data // head data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic do_wr;
    logic do_rd;
    // status from pointers
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    // storage write
    always_ff @(posedge clk) begin
        if (ce && do_wr) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
    // pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (ce) begin
            if (flush) begin
                rd_q <= wr_q + (AW+1)'(do_wr);
            end else if (do_rd) begin
                rd_q <= rd_q + 1'b1;
            end
            if (do_wr) begin
                wr_q <= wr_q + 1'b1;
            end
        end
    end
endmodule // ipc_fifo

//--- ipc_mem_model.sv
// Purpose: memory load pipeline stand-in facing the prefetch cache
// Assumes: answers in order, word data derived from its own address
// Notes: requests may be held off; latency switches between 2 and 4 cycles
`timescale 1ns/1ps
module ipc_mem_model (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic hold, // refuse new requests
    input wire logic slow, // long latency
    input wire logic fetch_req, // word request
    input wire logic [31:0] fetch_addr, // word address
    output logic fetch_accept, // request taken
    output logic fetch_valid, // word returns
    output logic [31:0] fetch_data // returned word
);
    logic [31:0] q[$];
    int age = 0;
    initial fetch_valid = 1'b0;
    initial fetch_data = 32'h0000_0000;
    // the cache alone keeps its depth limit
    assign fetch_accept = fetch_req && !hold;
    // in-order answers; data lines toggle when nothing is returned
    always @(posedge clk) begin
        fetch_valid <= 1'b0;
        fetch_data <= ~fetch_data;
        if (rst) begin
            q = {};
            age = 0;
        end else begin
            if (q.size() > 0 && age >= (slow ? 3 : 1)) begin
                fetch_valid <= 1'b1;
                fetch_data <= {q[0][17:2], ~q[0][17:2]};
                void'(q.pop_front());
                age = 0;
            end else if (q.size() > 0) begin
                age++;
            end
            if (fetch_req && fetch_accept) q.push_back(fetch_addr);
        end
    end
endmodule // ipc_mem_model

//--- ipc_pkg.sv
// Purpose: shared constants for the instruction prefetch cache
// Assumes: 32-bit byte addresses, halfword-aligned instruction pointer
// Notes: shared offsets, positions and counts live here; ipc_store fixes its own port widths
package ipc_pkg;
    localparam int IPC_ADDR_W = 32;
    localparam int IPC_WORD_W = 32;
    localparam int IPC_WORDS = 32;
    localparam int IPC_SLOT_LSB = 2;
    localparam int IPC_SLOT_MSB = 6;
    localparam int IPC_HW_LSB = 1;
    localparam int IPC_PREFETCH_LIMIT = 8;
    localparam int IPC_PIPE_DEPTH = 2;
    localparam int IPC_FWD_SLACK_WORDS = 2;
    localparam int IPC_FIFO_DEPTH = 16;
    localparam int IPC_LOOP_HOLD_BIT = 4;
    localparam logic [31:0] IPC_WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] IPC_FWD_SLACK = 32'h0000_0008;
    localparam logic [31:0] IPC_LIMIT_BYTES = 32'h0000_0020;
    // branch kinds seen by the cache
    typedef enum logic [2:0] {
        IPC_BR_NONE,
        IPC_BR_SHORT,
        IPC_BR_SHORT_DELAYED,
        IPC_BR_LONG,
        IPC_BR_RETURN,
        IPC_BR_OTHER
    } ipc_branch_type;
endpackage : ipc_pkg

//--- ipc_store.sv
// Purpose: circular word store with halfword read port
// Assumes: slot index from address bits 6..2, halfword from 6..1
// Notes: three halfwords read combinationally from the pointer
`timescale 1ns/1ps
module ipc_store
    import ipc_pkg::*;
#(
    parameter int WORDS = IPC_WORDS
) (
    input wire logic clk, // clock
    input wire logic ce, // clock enable
    input wire logic wr_en, // write a word
    input wire logic [4:0] wr_slot, // slot to write
    input wire logic [IPC_WORD_W-1:0] wr_data, // word data
    input wire logic [5:0] rd_hw, // first halfword address
    output logic [47:0] rd_data // three halfwords, first in high bits
);
    initial begin
        if (WORDS != 32) $error("slot index is five bits");
    end
    logic [IPC_WORD_W-1:0] mem_q [WORDS];
    logic [5:0] hw1;
    logic [5:0] hw2;
    // memory write
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem_q[wr_slot] <= wr_data;
        end
    end
    // halfword pick, high half of word is the lower address
    function automatic logic [15:0] pick(input logic [5:0] hw);
        logic [IPC_WORD_W-1:0] w;
        w = mem_q[hw[5:1]];
        pick = hw[0] ? w[15:0] : w[31:16];
    endfunction
    assign hw1 = rd_hw + 6'h01; // wraps modulo 64
    assign hw2 = rd_hw + 6'h02;
    assign rd_data = {pick(rd_hw), pick(hw1), pick(hw2)};
endmodule // ipc_store

//--- tb.sv
// Purpose: self-checking bench for the instruction prefetch cache
// Assumes: inputs driven on the falling edge, memory stand-in in order
// Notes: reference model tracks look-ahead, look-back and loop-hold
`timescale 1ns/1ps
module tb;
    import ipc_pkg::*;
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
    localparam logic [31:0] START = 32'h0000_0100;
    logic clk = 0, rst = 1, hold = 0, stall = 0, slow = 0;
    logic fetch_req, fetch_accept, fetch_valid, dec_ready, loop_hold, target_cached;
    logic [31:0] fetch_addr, fetch_data, ip = START, tgt = 0, snap;
    logic [47:0] dec_data, got;
    logic [1:0] len = 1, len_p = 1;
    logic pause = 0, mem = 0, br = 0, dly = 0, frame = 0, swr = 0, sbit = 0, ret = 0;
    logic saved = 1, lh = 0, flush_exp = 0;
    ipc_branch_type kind = IPC_BR_NONE;
    int n_mismatch = 0, comparisons = 0, outst = 0;
    logic [31:0] exp_next = START, lb_base = START, ip_p1 = START, ip_p2 = START;
    logic [15:0] lfsr = 16'h0061;
    ipc_branch_type kinds[9] = '{IPC_BR_SHORT, IPC_BR_SHORT, IPC_BR_SHORT,
        IPC_BR_SHORT_DELAYED, IPC_BR_LONG, IPC_BR_SHORT, IPC_BR_RETURN,
        IPC_BR_SHORT, IPC_BR_OTHER};
    int modes[9] = '{0, 1, 2, 2, 3, 4, 5, 6, 7};

    ipc_cache #(.START_ADDR(START)) dut (
        .clk(clk), .rst(rst), .ce(1'b1), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_accept(fetch_accept), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
        .instruction_pointer(ip), .dec_len(len), .dec_ready(dec_ready),
        .dec_data(dec_data), .pause_next(pause), .mem_exec(mem), .branch_taken(br),
        .branch_kind(kind), .in_delay_slot(dly), .branch_target(tgt),
        .frame_exec(frame), .status_wr(swr), .status_wr_bit(sbit),
        .return_restore(ret), .saved_loop_hold(saved), .loop_hold(loop_hold),
        .target_cached(target_cached));
    ipc_mem_model u_mem (
        .clk(clk), .rst(rst), .hold(hold || stall), .slow(slow), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_accept(fetch_accept), .fetch_valid(fetch_valid),
        .fetch_data(fetch_data));

    // clock and random stalls
    always #5 clk = ~clk;
    always @(negedge clk) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        stall <= lfsr[1] & lfsr[2];
        slow <= lfsr[0];
    end

    // expected halfwords, high half of a word holds the lower address
    function automatic logic [47:0] exp_dec(input logic [31:0] a, input logic [1:0] n);
        logic [47:0] r;
        logic [31:0] h;
        r = '0;
        for (int k = 0; k < 3; k++) begin
            h = a + 32'(2 * k);
            if (k < n) r[47 - 16 * k -: 16] = h[1] ? ~h[17:2] : h[17:2];
        end
        return r;
    endfunction

    //----------------------------------------
    // reference model
    //----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            exp_next = START;
            lb_base = START;
            lh = 0;
            outst = 0;
        end else begin
            `CHK("loop_hold", lh, loop_hold)
            got = dec_data & ~({48{1'b1}} >> (16 * len_p));
            if (dec_ready === 1'b1)
                `CHK("dec_data", exp_dec(ip_p1, len_p), got)
            if (fetch_req && fetch_accept) begin
                `CHK("fetch_addr", exp_next, fetch_addr)
                if (ip == ip_p1 && ip == ip_p2)
                    `CHK("limit", 1'b1, fetch_addr <= {ip[31:2], 2'b00} + 32)
                exp_next = exp_next + 4;
            end
            outst = outst + (fetch_req && fetch_accept) - fetch_valid;
            `CHK("outstanding", 1'b1, outst <= 2)
            if (ret) lh = saved;
            else if (frame || (br && kind != IPC_BR_SHORT_DELAYED)) lh = 1'b0;
            else if (swr) lh = sbit;
            if (br && flush_exp) begin
                exp_next = {tgt[31:2], 2'b00};
                lb_base = exp_next;
            end
        end
        ip_p2 = ip_p1;
        ip_p1 = ip;
        len_p = len;
    end

    //----------------------------------------
    // tasks
    //----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_ready();
        int t;
        t = 0;
        @(negedge clk);
        while (dec_ready !== 1'b1 && t < 300) begin
            @(negedge clk);
            t++;
        end
        `CHK("dec_ready", 1'b1, dec_ready)
    endtask

    task automatic settle();
        logic [31:0] la0, lim;
        la0 = exp_next - 4;
        lim = {ip[31:2], 2'b00} + 32;
        tick(60);
        `CHK("lookahead", (la0 > lim) ? la0 : lim, exp_next - 4)
    endtask

    task automatic branch(input ipc_branch_type k, input logic d, input int m);
        logic [31:0] la, lb, t;
        logic cached;
        la = exp_next - 4;
        lb = (la >= lb_base + 124) ? la - 124 : lb_base;
        // targets stay far from any memory block tail
        t = m == 0 ? lb : m == 1 ? la + 8 : m == 2 ? la + 12 : m == 3 ? ip - 4 :
            m == 4 ? lb - 4 : m == 5 ? ip + 64 : m == 6 ? ip + 2 : ip + 100;
        cached = (k == IPC_BR_SHORT || k == IPC_BR_SHORT_DELAYED) && !d &&
            ((t < ip) ? t >= lb : t <= la + 8);
        flush_exp = !cached && !(k == IPC_BR_SHORT_DELAYED && t > ip && lh);
        pause = 1;
        hold = 1;
        tick(1);
        pause = 0;
        br = 1;
        kind = k;
        dly = d;
        tgt = t;
        ret = (k == IPC_BR_RETURN);
        tick(1);
        br = 0;
        ret = 0;
        dly = 0;
        ip = t;
        hold = 0;
        tick(2);
        if (k == IPC_BR_SHORT || k == IPC_BR_SHORT_DELAYED)
            `CHK("target_cached", cached, target_cached)
        wait_ready();
        settle();
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    //----------------------------------------
    // main sequence
    //----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) rst = 0;
        `CHK("dec_ready", 1'b0, dec_ready)
        settle();
        $display("test fill done");
        // straight-line decode across the buffer wrap
        for (int i = 0; i < 40; i++) begin
            len = 2'(lfsr % 3) + 2'd1;
            wait_ready();
            ip = ip + 32'(2 * len);
        end
        settle();
        $display("test stream done");
        // memory execution and a pending branch both hold prefetch
        for (int i = 0; i < 2; i++) begin
            mem = (i == 0);
            pause = (i == 1);
            tick(2);
            snap = exp_next;
            ip = ip + 8;
            tick(6);
            `CHK("held", snap, exp_next)
            mem = 0;
            pause = 0;
            settle();
        end
        $display("test pause done");
        // frame clear beats a simultaneous status write
        swr = 1;
        sbit = 1;
        frame = 1;
        tick(1);
        frame = 0;
        tick(1);
        swr = 0;
        tick(2);
        $display("test loop_hold done");
        for (int i = 0; i < 9; i++) begin
            if (i == 3 || i == 8) begin
                swr = 1;
                sbit = 1;
                tick(1);
                swr = 0;
                tick(1);
            end
            branch(kinds[i], i == 7, modes[i]);
        end
        $display("test branch done");
        finish_test();
    end

    // watchdog
    initial begin
        #300000;
        n_mismatch++;
        finish_test();
    end
endmodule // tb
